// ==== rtl/rtc_i2c_slave.sv ====
`timescale 1ns/1ps
`include "rtc_regs.svh"

// Overview of operation
// - Stay in reset while oscillator stopped.
// - Reset clears bus logic, pointer, loads patterns.
// - No bus activity during internal reset.
// - Control/status one 08h, two 00h.
// - Seconds and alarm bit 7 set.
// - Clock-output control: bit7 set, bits1:0 cleared.
// - Countdown control: bit7 cleared, bits1:0 set.
// - Undefined bits untouched by reset.
// - Override sequence ends reset immediately.
// - Writing test bit zero cancels override.
// - No override re-entry until test bit one.
// - Clearing test bit otherwise has no effect.
// - Data changes during clock-high are conditions.
// - Falling data is START, rising is STOP.
// - Unlimited bytes, each followed by acknowledge.
// - Acknowledge every received byte when addressed.
// - Hold data low through acknowledge clock-high.
// - Master nack ends read; release data line.
// - First byte is address; slave only.
// - Answer A3h read, A2h write only.
// - Pointer from low four bits.
module rtc_i2c_slave
    import rtc_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic       osc_running_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    output logic            in_reset_o,
    output logic            override_o,
    output logic [7:0]      ctrl_status_one_o
);

    rtc_pins_s  pins_m_q;
    rtc_pins_s  pins_s_q;
    rtc_pins_s  pins_p_q;
    logic       osc_m_q;
    logic       osc_s_q;
    rtc_state_e state_q;
    logic [3:0] cnt_q;
    logic [7:0] shreg_q;
    logic [7:0] tx_q;
    logic [3:0] ptr_q;
    logic       rw_q;
    logic       low_q;
    logic       ovr_q;
    logic       arm_q;
    logic       in_reset_q;
    logic       sda_o_q;
    logic [7:0] regs_q [`RTC_NUM_REGS];

    logic       int_rst;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_c;
    logic       stop_c;
    logic       wr_done;
    logic       ptr_done;
    logic       rd_done;

    // Two-flop synchronisers for pins and oscillator status
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            pins_m_q <= '1;
            pins_s_q <= '1;
            pins_p_q <= '1;
            osc_m_q  <= 1'b0;
            osc_s_q  <= 1'b0;
        end else begin
            pins_m_q <= '{scl: scl_i, sda: sda_i};
            pins_s_q <= pins_m_q;
            pins_p_q <= pins_s_q;
            osc_m_q  <= osc_running_i;
            osc_s_q  <= osc_m_q;
        end
    end

    assign int_rst  = !resetn_i || (!osc_s_q && !ovr_q);
    assign scl_rise = pins_s_q.scl && !pins_p_q.scl;
    assign scl_fall = !pins_s_q.scl && pins_p_q.scl;
    assign start_c  = pins_s_q.scl && pins_p_q.scl && pins_p_q.sda && !pins_s_q.sda;
    assign stop_c   = pins_s_q.scl && pins_p_q.scl && !pins_p_q.sda && pins_s_q.sda;
    assign ptr_done = (state_q == ST_PTR) && scl_fall && (cnt_q == `RTC_BYTE_BITS);
    assign wr_done  = (state_q == ST_WR) && scl_fall && (cnt_q == `RTC_BYTE_BITS);
    assign rd_done  = (state_q == ST_RD) && scl_fall && (cnt_q == `RTC_LAST_BIT);

    // Protocol state machine; data only sampled on clock-high edges
    always_ff @(posedge clk_i) begin
        if (int_rst) begin
            state_q <= ST_IDLE;
            cnt_q   <= `RTC_CNT_ZERO;
            shreg_q <= '0;
            tx_q    <= '0;
            rw_q    <= 1'b0;
            low_q   <= 1'b0;
        end else if (start_c) begin
            state_q <= ST_DEV;
            cnt_q   <= `RTC_CNT_ZERO;
            low_q   <= 1'b0;
        end else if (stop_c) begin
            state_q <= ST_IDLE;
            low_q   <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                end
                ST_DEV, ST_PTR, ST_WR: begin
                    if (scl_rise && cnt_q != `RTC_BYTE_BITS) begin
                        shreg_q <= {shreg_q[6:0], pins_s_q.sda};
                        cnt_q   <= cnt_q + `RTC_CNT_ONE;
                    end else if (scl_fall && cnt_q == `RTC_BYTE_BITS) begin
                        cnt_q <= `RTC_CNT_ZERO;
                        if (state_q == ST_DEV) begin
                            if (shreg_q == `RTC_ADDR_RD || shreg_q == `RTC_ADDR_WR) begin
                                state_q <= ST_DEV_ACK;
                                low_q   <= 1'b1;
                                rw_q    <= shreg_q[0];
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end else if (state_q == ST_PTR) begin
                            state_q <= ST_PTR_ACK;
                            low_q   <= 1'b1;
                        end else begin
                            state_q <= ST_WR_ACK;
                            low_q   <= 1'b1;
                        end
                    end
                end
                ST_DEV_ACK: begin
                    if (scl_fall) begin
                        if (rw_q) begin
                            state_q <= ST_RD;
                            tx_q    <= regs_q[ptr_q];
                            low_q   <= !regs_q[ptr_q][7];
                        end else begin
                            state_q <= ST_PTR;
                            low_q   <= 1'b0;
                        end
                    end
                end
                ST_PTR_ACK, ST_WR_ACK: begin
                    if (scl_fall) begin
                        state_q <= ST_WR;
                        low_q   <= 1'b0;
                    end
                end
                ST_RD: begin
                    if (scl_fall) begin
                        if (cnt_q == `RTC_LAST_BIT) begin
                            state_q <= ST_RD_ACK;
                            cnt_q   <= `RTC_CNT_ZERO;
                            low_q   <= 1'b0;
                        end else begin
                            tx_q  <= {tx_q[6:0], 1'b0};
                            low_q <= !tx_q[6];
                            cnt_q <= cnt_q + `RTC_CNT_ONE;
                        end
                    end
                end
                ST_RD_ACK: begin
                    if (scl_rise && pins_s_q.sda) begin
                        state_q <= ST_IDLE;
                    end else if (scl_fall) begin
                        state_q <= ST_RD;
                        tx_q    <= regs_q[ptr_q];
                        low_q   <= !regs_q[ptr_q][7];
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    low_q   <= 1'b0;
                end
            endcase
        end
    end

    // Register pointer
    always_ff @(posedge clk_i) begin
        if (int_rst) begin
            ptr_q <= `RTC_PTR_ZERO;
        end else if (ptr_done) begin
            ptr_q <= shreg_q[3:0];
        end else if (wr_done || rd_done) begin
            ptr_q <= ptr_q + `RTC_PTR_ONE;
        end
    end

    function automatic logic [7:0] rst_val(input logic [3:0] a, input logic [7:0] v);
        logic [7:0] r;
        r = v;
        case (a)
            `RTC_OFF_CS1:     r = `RTC_CS1_RST;
            `RTC_OFF_CS2:     r = `RTC_CS2_RST;
            `RTC_OFF_SEC,
            `RTC_OFF_ALM_MIN,
            `RTC_OFF_ALM_HR,
            `RTC_OFF_ALM_DAY,
            `RTC_OFF_ALM_WKD: r = v | `RTC_MSB_MASK;
            `RTC_OFF_CLKOUT:  r = (v | `RTC_MSB_MASK) & ~`RTC_LOW2_MASK;
            `RTC_OFF_TMR_CTL: r = (v & ~`RTC_MSB_MASK) | `RTC_LOW2_MASK;
            default:          r = v;
        endcase
        return r;
    endfunction : rst_val

    // Register file; undefined bits have no reset term
    always_ff @(posedge clk_i) begin
        if (int_rst) begin
            for (int i = 0; i < `RTC_NUM_REGS; i++) begin
                regs_q[i] <= rst_val(4'(i), regs_q[i]);
            end
        end else if (wr_done) begin
            regs_q[ptr_q] <= shreg_q;
        end
    end

    // Reset override: while held in reset with the test bit set, a START
    // followed by a STOP releases the reset
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ovr_q <= 1'b0;
            arm_q <= 1'b0;
        end else if (ovr_q) begin
            arm_q <= 1'b0;
            if (wr_done && ptr_q == `RTC_OFF_CS1 && !shreg_q[`RTC_OVERRIDE_TEST_CONTROL_BIT_BIT]) begin
                ovr_q <= 1'b0;
            end
        end else if (!osc_s_q && regs_q[`RTC_OFF_CS1][`RTC_OVERRIDE_TEST_CONTROL_BIT_BIT]) begin
            if (start_c) begin
                arm_q <= 1'b1;
            end else if (stop_c && arm_q) begin
                ovr_q <= 1'b1;
                arm_q <= 1'b0;
            end
        end else begin
            arm_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            in_reset_q <= 1'b1;
            sda_o_q    <= 1'b0;
        end else begin
            in_reset_q <= int_rst;
            sda_o_q    <= 1'b0;
        end
    end

    assign sda_o             = sda_o_q;
    assign sda_oe_o          = low_q;
    assign in_reset_o        = in_reset_q;
    assign override_o        = ovr_q;
    assign ctrl_status_one_o = regs_q[`RTC_OFF_CS1];

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    chk_reset_quiet: assert property (int_rst |=> !sda_oe_o && state_q == ST_IDLE)
        else $error("bus active during internal reset");
    chk_hold_reset: assert property ((!osc_s_q && !ovr_q) |=> in_reset_o)
        else $error("reset not held while oscillator stopped");
    chk_ptr_clear: assert property (int_rst |=> ptr_q == `RTC_PTR_ZERO)
        else $error("pointer not cleared by reset");
    chk_cs_reset: assert property (int_rst |=> regs_q[`RTC_OFF_CS1] == `RTC_CS1_RST
        && regs_q[`RTC_OFF_CS2] == `RTC_CS2_RST)
        else $error("control/status reset value wrong");
    chk_msb_set: assert property (int_rst |=> regs_q[`RTC_OFF_SEC][7]
        && regs_q[`RTC_OFF_ALM_WKD][7])
        else $error("seconds or alarm bit 7 not set");
    chk_clkout_rst: assert property (int_rst |=> regs_q[`RTC_OFF_CLKOUT][7]
        && regs_q[`RTC_OFF_CLKOUT][1:0] == 2'h0
        && regs_q[`RTC_OFF_TMR_CTL][1:0] == 2'h3 && !regs_q[`RTC_OFF_TMR_CTL][7])
        else $error("clock-output or countdown control reset wrong");
    chk_keep_undef: assert property (int_rst |=> regs_q[4'h3] === $past(regs_q[4'h3]))
        else $error("undefined register changed by reset");
    chk_ovr_enter: assert property (!ovr_q && arm_q && stop_c && !osc_s_q
        && regs_q[`RTC_OFF_CS1][`RTC_OVERRIDE_TEST_CONTROL_BIT_BIT] |=> ovr_q ##1 !in_reset_o)
        else $error("override not entered");
    chk_ovr_clear: assert property (ovr_q && wr_done && ptr_q == `RTC_OFF_CS1
        && !shreg_q[`RTC_OVERRIDE_TEST_CONTROL_BIT_BIT] |=> !ovr_q)
        else $error("override not cancelled");
    chk_ack_low: assert property ($rose(state_q == ST_WR_ACK) && !int_rst |-> sda_oe_o
        throughout (state_q == ST_WR_ACK)[*2])
        else $error("acknowledge not held low");
    chk_ptr_step: assert property ((wr_done || rd_done) && !int_rst
        |=> ptr_q == $past(ptr_q) + `RTC_PTR_ONE)
        else $error("pointer did not advance");
    chk_bad_addr: assert property ((state_q == ST_DEV) && scl_fall && cnt_q == `RTC_BYTE_BITS
        && shreg_q != `RTC_ADDR_RD && shreg_q != `RTC_ADDR_WR && !start_c && !stop_c
        |=> state_q == ST_IDLE && !sda_oe_o)
        else $error("foreign address answered");

endmodule : rtc_i2c_slave

// ==== rtl/rtc_pkg.sv ====
package rtc_pkg;

    typedef struct packed {
        logic scl;
        logic sda;
    } rtc_pins_s;

    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0000,
        ST_DEV     = 4'b0001,
        ST_DEV_ACK = 4'b0010,
        ST_PTR     = 4'b0011,
        ST_PTR_ACK = 4'b0100,
        ST_WR      = 4'b0101,
        ST_WR_ACK  = 4'b0110,
        ST_RD      = 4'b0111,
        ST_RD_ACK  = 4'b1000
    } rtc_state_e;

endpackage : rtc_pkg

// ==== rtl/rtc_regs.svh ====
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

// Register offsets (4-bit pointer)
`define RTC_OFF_CS1      4'h0
`define RTC_OFF_CS2      4'h1
`define RTC_OFF_SEC      4'h2
`define RTC_OFF_ALM_MIN  4'h9
`define RTC_OFF_ALM_HR   4'hA
`define RTC_OFF_ALM_DAY  4'hB
`define RTC_OFF_ALM_WKD  4'hC
`define RTC_OFF_CLKOUT   4'hD
`define RTC_OFF_TMR_CTL  4'hE

// Reset patterns
`define RTC_CS1_RST      8'h08
`define RTC_CS2_RST      8'h00
`define RTC_MSB_MASK     8'h80
`define RTC_LOW2_MASK    8'h03
`define RTC_OVERRIDE_TEST_CONTROL_BIT_BIT    3

// Slave addresses
`define RTC_ADDR_RD      8'hA3
`define RTC_ADDR_WR      8'hA2

// Bit counting
`define RTC_BYTE_BITS    4'h8
`define RTC_LAST_BIT     4'h7
`define RTC_CNT_ZERO     4'h0
`define RTC_CNT_ONE      4'h1
`define RTC_PTR_ZERO     4'h0
`define RTC_PTR_ONE      4'h1
`define RTC_NUM_REGS     16

`endif

// ==== verif/rtc_i2c_master.sv ====
`timescale 1ns/1ps

module rtc_i2c_master (
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_oe_o
);
    real q;

    // Both lines released: bus idle, clock parked high between frames
    initial begin
        q        = 31.25;
        scl_o    = 1'b1;
        sda_oe_o = 1'b0;
    end

    task automatic bit_io(input logic b, output logic r);
        #(q);
        sda_oe_o = !b;   // Data moves only while the clock is low
        #(q);
        scl_o = 1'b1;
        #(q);
        r = sda_i;
        #(q);
        scl_o = 1'b0;
    endtask : bit_io

    // Called on an idle bus or mid-frame for a repeated start
    task automatic start();
        #(q);
        sda_oe_o = 1'b0;
        #(q);
        scl_o = 1'b1;
        #(q);
        sda_oe_o = 1'b1;   // Falling data with clock high
        #(q);
        scl_o = 1'b0;
    endtask : start

    task automatic stop();
        #(q);
        sda_oe_o = 1'b1;
        #(q);
        scl_o = 1'b1;
        #(q);
        sda_oe_o = 1'b0;   // Rising data with clock high
        #(q);
    endtask : stop

    // Eight bits MSB first, then one acknowledge clock
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask : wbyte

    // Acknowledge by pulling low, leave the last byte unacknowledged
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(last, r);
    endtask : rbyte
endmodule : rtc_i2c_master

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
`include "rtc_regs.svh"

module tb_top;
    import rtc_pkg::*;

    logic       clk_i;
    logic       resetn_i;
    logic       osc_running_i;
    logic       sda_o;
    logic       sda_oe_o;
    logic       in_reset_o;
    logic       override_o;
    logic [7:0] ctrl_status_one_o;
    logic       m_scl;
    logic       m_oe;
    rtc_pins_s  pins;
    int         err_total;
    int         check_count;
    int         cycles;

    // Open-drain wire with pull-up
    assign pins.scl = m_scl;
    assign pins.sda = !(m_oe || (sda_oe_o && !sda_o));

    rtc_i2c_slave i_rtc_i2c_slave (
        .clk_i             (clk_i),
        .resetn_i          (resetn_i),
        .osc_running_i     (osc_running_i),
        .scl_i             (pins.scl),
        .sda_i             (pins.sda),
        .sda_o             (sda_o),
        .sda_oe_o          (sda_oe_o),
        .in_reset_o        (in_reset_o),
        .override_o        (override_o),
        .ctrl_status_one_o (ctrl_status_one_o)
    );

    rtc_i2c_master i_rtc_i2c_master (
        .sda_i    (pins.sda),
        .scl_o    (m_scl),
        .sda_oe_o (m_oe)
    );

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = !clk_i;
    end

    task automatic conclude();
        $display("Checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 60000) begin
            err_total++;
            $display("Error timeout expected done seen hang");
            conclude();
        end
    end

    task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk8

    task automatic wait_flag(input logic exp);
        for (int n = 0; n < 40 && in_reset_o !== exp; n++) @(posedge clk_i);
        repeat (2) @(posedge clk_i);
        chk8("in_reset", {7'h00, exp}, {7'h00, in_reset_o});
    endtask : wait_flag

    task automatic send(input logic [7:0] d, input logic exp_ack);
        logic ack;
        i_rtc_i2c_master.wbyte(d, ack);
        chk8("ack", {7'h00, exp_ack}, {7'h00, ack});
    endtask : send

    task automatic wr_regs(input logic [7:0] ptr, input logic [7:0] d[$]);
        i_rtc_i2c_master.start();
        send(`RTC_ADDR_WR, 1'b1);
        send(ptr, 1'b1);
        foreach (d[i]) send(d[i], 1'b1);
        i_rtc_i2c_master.stop();
    endtask : wr_regs

    task automatic rd_regs(input logic [7:0] ptr, input logic [7:0] e[$]);
        logic [7:0] v;
        i_rtc_i2c_master.start();
        send(`RTC_ADDR_WR, 1'b1);
        send(ptr, 1'b1);
        i_rtc_i2c_master.start();
        send(`RTC_ADDR_RD, 1'b1);
        foreach (e[i]) begin
            i_rtc_i2c_master.rbyte(i == e.size() - 1, v);
            chk8("read_data", e[i], v);
        end
        i_rtc_i2c_master.stop();
        chk8("sda_release", 8'h00, {7'h00, sda_oe_o});
    endtask : rd_regs

    task automatic t_por();
        repeat (6) @(posedge clk_i);
        chk8("in_reset", 8'h01, {7'h00, in_reset_o});
        chk8("override", 8'h00, {7'h00, override_o});
        chk8("reg00", `RTC_CS1_RST, ctrl_status_one_o);
        $display("t_por done errors %0d", err_total);
    endtask : t_por

    task automatic t_bus_in_reset();
        @(posedge clk_i) resetn_i <= 1'b0;
        i_rtc_i2c_master.start();
        send(`RTC_ADDR_WR, 1'b0);
        i_rtc_i2c_master.stop();
        @(posedge clk_i) resetn_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk8("override", 8'h00, {7'h00, override_o});
        $display("t_bus_in_reset done errors %0d", err_total);
    endtask : t_bus_in_reset

    task automatic t_override();
        i_rtc_i2c_master.start();
        i_rtc_i2c_master.stop();
        wait_flag(1'b0);
        chk8("override", 8'h01, {7'h00, override_o});
        // Clearing the test bit drops back into reset before the acknowledge
        i_rtc_i2c_master.start();
        send(`RTC_ADDR_WR, 1'b1);
        send(8'h00, 1'b1);
        send(8'h00, 1'b0);
        i_rtc_i2c_master.stop();
        repeat (6) @(posedge clk_i);
        chk8("override", 8'h00, {7'h00, override_o});
        wait_flag(1'b1);
        chk8("reg00", `RTC_CS1_RST, ctrl_status_one_o);
        $display("t_override done errors %0d", err_total);
    endtask : t_override

    task automatic t_normal();
        @(posedge clk_i) osc_running_i <= 1'b1;
        wait_flag(1'b0);
        wr_regs(8'h00, {8'h00});
        repeat (6) @(posedge clk_i);
        chk8("in_reset", 8'h00, {7'h00, in_reset_o});
        chk8("override", 8'h00, {7'h00, override_o});
        chk8("reg00", 8'h00, ctrl_status_one_o);
        i_rtc_i2c_master.start();
        send(8'hA0, 1'b0);
        i_rtc_i2c_master.stop();
        $display("t_normal done errors %0d", err_total);
    endtask : t_normal

    task automatic t_wrap();
        wr_regs(8'hFE, {8'h55, 8'hAA, 8'h12, 8'h34});
        chk8("reg00", 8'h12, ctrl_status_one_o);
        rd_regs(8'h3E, {8'h55, 8'hAA, 8'h12, 8'h34});
        $display("t_wrap done errors %0d", err_total);
    endtask : t_wrap

    task automatic t_reset_vals();
        logic [7:0] fill[$];
        repeat (16) fill.push_back(8'h5A);
        wr_regs(8'h00, fill);
        @(posedge clk_i) osc_running_i <= 1'b0;
        wait_flag(1'b1);
        chk8("reg00", `RTC_CS1_RST, ctrl_status_one_o);
        @(posedge clk_i) osc_running_i <= 1'b1;
        wait_flag(1'b0);
        // Slow master for this transfer
        i_rtc_i2c_master.q = 62.5;
        rd_regs(8'h00, {8'h08, 8'h00, 8'hDA, 8'h5A, 8'h5A, 8'h5A, 8'h5A, 8'h5A,
                        8'h5A, 8'hDA, 8'hDA, 8'hDA, 8'hDA, 8'hD8, 8'h5B, 8'h5A});
        i_rtc_i2c_master.q = 31.25;
        $display("t_reset_vals done errors %0d", err_total);
    endtask : t_reset_vals

    initial begin
        err_total     = 0;
        check_count   = 0;
        cycles        = 0;
        resetn_i      = 1'b0;
        osc_running_i = 1'b0;
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        t_por();
        t_bus_in_reset();
        t_override();
        t_normal();
        t_wrap();
        t_reset_vals();
        conclude();
    end
endmodule : tb_top
